// ### hw/asq_cmd_unit.sv
// Auto sequence command unit: APB command registers and sequence runner
// How it works
// - FILE write 1..9 selects current file; FILE read returns it.
// - STEP write 1..16 selects current step; STEP read returns it.
// - TOTAL write 1..16 sets step count of current file; readable.
// - BANK write 1..150 binds a stored state to current step; readable.
// - TIME write 100..9999 sets current step duration in milliseconds.
// - SAVE write commits edited data of the current file to storage.
// - REPEAT write 0..9999 sets current file repeat count; readable.
// - RUN write 1..9 starts automatic execution of that file.
// - Run completion raises an unsolicited reply pulse and sticky flag.
// - Each executed step recalls its assigned state slot 1..150.
// - Status testing bit reads 1 while running, 0 after the end.
`timescale 1ns/1ns
module asq_cmd_unit
  import asq_pkg::*;
#(
  parameter int CYC_PER_MS = CYCLES_PER_MS
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   recall_valid,
  output logic      [BANK_W-1:0] recall_slot,
  output logic                   done_reply,
  output logic                   testing
);
  // ---------------------------------------------------------------
  // Storage: working copy being edited and committed copy that runs
  // ---------------------------------------------------------------
  logic [BANK_W-1:0] work_bank  [0:8][0:15];
  logic [TIME_W-1:0] work_time  [0:8][0:15];
  logic [STEP_W-1:0] work_total [0:8];
  logic [TIME_W-1:0] work_rep   [0:8];
  logic [BANK_W-1:0] sv_bank    [0:8][0:15];
  logic [TIME_W-1:0] sv_time    [0:8][0:15];
  logic [STEP_W-1:0] sv_total   [0:8];
  logic [TIME_W-1:0] sv_rep     [0:8];
  logic [FILE_W-1:0] cur_file;
  logic [STEP_W-1:0] cur_step;
  logic [3:0]        fidx;
  logic [3:0]        sidx;
  logic              done_flag;
  logic              reject_flag;
  typedef enum logic [1:0] {ASQ_IDLE, ASQ_LOAD, ASQ_HOLD} asq_state_t;
  asq_state_t        state;
  logic [3:0]        run_f;
  logic [STEP_W-1:0] run_step;
  logic [TIME_W-1:0] run_pass;
  logic              tmr_start;
  logic              tmr_expired;
  assign fidx = 4'(cur_file - RST_FILE);
  assign sidx = 4'(cur_step - RST_STEP);
  // ---------------------------------------------------------------
  // APB decode: zero wait states, unmapped address answers pslverr
  // ---------------------------------------------------------------
  logic acc;
  logic mapped;
  logic wr_file, wr_step, wr_total, wr_bank, wr_time, wr_save, wr_rep, wr_run, wr_stat;
  logic ok_file, ok_step, ok_bank, ok_time, ok_rep;
  assign pready   = 1'b1;
  assign acc      = psel & penable;
  assign mapped   = (paddr <= OFS_STATUS) && (paddr[1:0] == 2'b00);
  assign pslverr  = acc & ~mapped;
  assign wr_file  = acc & pwrite & (paddr == OFS_FILE);
  assign wr_step  = acc & pwrite & (paddr == OFS_STEP);
  assign wr_total = acc & pwrite & (paddr == OFS_TOTAL);
  assign wr_bank  = acc & pwrite & (paddr == OFS_BANK);
  assign wr_time  = acc & pwrite & (paddr == OFS_TIME);
  assign wr_save  = acc & pwrite & (paddr == OFS_SAVE);
  assign wr_rep   = acc & pwrite & (paddr == OFS_REPEAT);
  assign wr_run   = acc & pwrite & (paddr == OFS_RUN);
  assign wr_stat  = acc & pwrite & (paddr == OFS_STATUS);
  // Range checks shared by several commands
  assign ok_file  = (pwdata >= FILE_MIN) && (pwdata <= FILE_MAX);
  assign ok_step  = (pwdata >= STEP_MIN) && (pwdata <= STEP_MAX);
  assign ok_bank  = (pwdata >= BANK_MIN) && (pwdata <= BANK_MAX);
  assign ok_time  = (pwdata >= TIME_MIN) && (pwdata <= TIME_MAX);
  assign ok_rep   = (pwdata <= REPEAT_MAX);
  logic bad_wr;
  logic run_ok;
  assign run_ok = wr_run & ok_file & (state == ASQ_IDLE);
  assign bad_wr = ((wr_file | wr_run) & ~ok_file) | ((wr_step | wr_total) & ~ok_step)
                | (wr_bank & ~ok_bank) | (wr_time & ~ok_time) | (wr_rep & ~ok_rep)
                | (wr_run & (state != ASQ_IDLE));
  // ---------------------------------------------------------------
  // Selection registers
  // ---------------------------------------------------------------
  // Current file and step only move on legal values
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cur_file <= RST_FILE;
      cur_step <= RST_STEP;
    end else begin
      if (wr_file && ok_file) begin
        cur_file <= pwdata[FILE_W-1:0];
      end
      if (wr_step && ok_step) begin
        cur_step <= pwdata[STEP_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Working edit data
  // ---------------------------------------------------------------
  // BANK and TIME act on the step chosen earlier, so STEP must come first
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int f = 0; f < 9; f++) begin
        work_total[f] <= RST_STEP;
        work_rep[f]   <= RST_REP;
        for (int s = 0; s < 16; s++) begin
          work_bank[f][s] <= RST_BANK;
          work_time[f][s] <= RST_TIME;
        end
      end
    end else begin
      if (wr_total && ok_step) begin
        work_total[fidx] <= pwdata[STEP_W-1:0];
      end
      if (wr_bank && ok_bank) begin
        work_bank[fidx][sidx] <= pwdata[BANK_W-1:0];
      end
      if (wr_time && ok_time) begin
        work_time[fidx][sidx] <= pwdata[TIME_W-1:0];
      end
      if (wr_rep && ok_rep) begin
        work_rep[fidx] <= pwdata[TIME_W-1:0];
      end
    end
  end

  // Commit of the whole current file in one cycle; a run reads only this copy
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int f = 0; f < 9; f++) begin
        sv_total[f] <= RST_STEP;
        sv_rep[f]   <= RST_REP;
        for (int s = 0; s < 16; s++) begin
          sv_bank[f][s] <= RST_BANK;
          sv_time[f][s] <= RST_TIME;
        end
      end
    end else if (wr_save) begin
      sv_total[fidx] <= work_total[fidx];
      sv_rep[fidx]   <= work_rep[fidx];
      for (int s = 0; s < 16; s++) begin
        sv_bank[fidx][s] <= work_bank[fidx][s];
        sv_time[fidx][s] <= work_time[fidx][s];
      end
    end
  end

  // ---------------------------------------------------------------
  // Status flags: hardware set wins over a software clear
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done_flag   <= 1'b0;
      reject_flag <= 1'b0;
    end else begin
      if (done_reply) begin
        done_flag <= 1'b1;
      end else if (wr_stat && pwdata[ST_DONE]) begin
        done_flag <= 1'b0;
      end
      if (bad_wr) begin
        reject_flag <= 1'b1;
      end else if (wr_stat && pwdata[ST_REJECT]) begin
        reject_flag <= 1'b0;
      end
    end
  end

  // Read mux: write-only command registers read as zero
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      OFS_FILE:   prdata[FILE_W-1:0] = cur_file;
      OFS_STEP:   prdata[STEP_W-1:0] = cur_step;
      OFS_TOTAL:  prdata[STEP_W-1:0] = work_total[fidx];
      OFS_BANK:   prdata[BANK_W-1:0] = work_bank[fidx][sidx];
      OFS_TIME:   prdata[TIME_W-1:0] = work_time[fidx][sidx];
      OFS_REPEAT: prdata[TIME_W-1:0] = work_rep[fidx];
      OFS_STATUS: begin
        prdata[ST_TESTING] = testing;
        prdata[ST_DONE]    = done_flag;
        prdata[ST_REJECT]  = reject_flag;
      end
      default:    prdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequence runner
  // ---------------------------------------------------------------
  // RUN while busy is refused rather than restarting a half-done test
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state        <= ASQ_IDLE;
      run_f        <= 4'h0;
      run_step     <= RST_STEP;
      run_pass     <= '0;
      recall_valid <= 1'b0;
      recall_slot  <= RST_BANK;
      done_reply   <= 1'b0;
    end else begin
      recall_valid <= 1'b0;
      done_reply   <= 1'b0;
      unique case (state)
        ASQ_IDLE: begin
          if (run_ok) begin
            run_f    <= 4'(pwdata[FILE_W-1:0] - RST_FILE);
            run_step <= RST_STEP;
            run_pass <= '0;
            state    <= ASQ_LOAD;
          end
        end
        ASQ_LOAD: begin
          recall_valid <= 1'b1;
          recall_slot  <= sv_bank[run_f][4'(run_step - RST_STEP)];
          state        <= ASQ_HOLD;
        end
        ASQ_HOLD: begin
          if (tmr_expired) begin
            if (run_step < sv_total[run_f]) begin
              run_step <= run_step + 5'h01;
              state    <= ASQ_LOAD;
            end else if (run_pass < sv_rep[run_f]) begin
              run_pass <= run_pass + 14'h0001;
              run_step <= RST_STEP;
              state    <= ASQ_LOAD;
            end else begin
              done_reply <= 1'b1;
              state      <= ASQ_IDLE;
            end
          end
        end
      endcase
    end
  end
  assign testing   = (state != ASQ_IDLE);
  assign tmr_start = (state == ASQ_LOAD);
  asq_ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (tmr_start),
    .ms_count (sv_time[run_f][4'(run_step - RST_STEP)]),
    .expired  (tmr_expired)
  );
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence seq_run_cmd;
    run_ok;
  endsequence
  sequence seq_first_step;
    testing ##1 (recall_valid && testing);
  endsequence
  AST_FILE_RANGE: assert property (cur_file >= 4'h1 && cur_file <= 4'h9)
    else $error("current file out of range");
  AST_STEP_SET: assert property (wr_step && ok_step |=> cur_step == $past(pwdata[4:0]))
    else $error("step select not taken");
  AST_TOTAL_SET: assert property (wr_total && ok_step |=>
    work_total[fidx] == $past(pwdata[4:0]))
    else $error("total step count not taken");
  AST_BANK_SET: assert property (wr_bank && ok_bank |=>
    work_bank[fidx][sidx] == $past(pwdata[7:0]))
    else $error("bank assign not taken");
  AST_TIME_REJECT: assert property (wr_time && !ok_time |=>
    $stable(work_time[fidx][sidx]) && reject_flag)
    else $error("out of range time stored");
  AST_REPEAT_SET: assert property (wr_rep && ok_rep |=>
    work_rep[fidx] == $past(pwdata[13:0]))
    else $error("repeat count not taken");
  AST_SAVE_COMMIT: assert property (wr_save |=> sv_total[fidx] == work_total[fidx])
    else $error("save did not commit");
  AST_RUN_START: assert property (seq_run_cmd |=> seq_first_step)
    else $error("run did not start");
  AST_DONE_END: assert property (done_reply |-> !testing ##1 done_flag)
    else $error("completion reply inconsistent");
  AST_RECALL_GAP: assert property (recall_valid |=> !recall_valid [*2])
    else $error("steps recalled too close");
endmodule : asq_cmd_unit

// ### hw/asq_pkg.sv
// Constants shared by the auto sequence command unit
package asq_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_FILE   = 8'h00;
  localparam logic [7:0] OFS_STEP   = 8'h04;
  localparam logic [7:0] OFS_TOTAL  = 8'h08;
  localparam logic [7:0] OFS_BANK   = 8'h0C;
  localparam logic [7:0] OFS_TIME   = 8'h10;
  localparam logic [7:0] OFS_SAVE   = 8'h14;
  localparam logic [7:0] OFS_REPEAT = 8'h18;
  localparam logic [7:0] OFS_RUN    = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // ---------------------------------------------------------------
  // Field widths, status bit positions
  // ---------------------------------------------------------------
  localparam int FILE_W = 4;
  localparam int STEP_W = 5;
  localparam int BANK_W = 8;
  localparam int TIME_W = 14;
  localparam int ST_TESTING = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_REJECT  = 2;
  // ---------------------------------------------------------------
  // Legal ranges and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] FILE_MIN   = 32'h0000_0001;
  localparam logic [31:0] FILE_MAX   = 32'h0000_0009;
  localparam logic [31:0] STEP_MIN   = 32'h0000_0001;
  localparam logic [31:0] STEP_MAX   = 32'h0000_0010;
  localparam logic [31:0] BANK_MIN   = 32'h0000_0001;
  localparam logic [31:0] BANK_MAX   = 32'h0000_0096;
  localparam logic [31:0] TIME_MIN   = 32'h0000_0064;
  localparam logic [31:0] TIME_MAX   = 32'h0000_270F;
  localparam logic [31:0] REPEAT_MAX = 32'h0000_270F;
  localparam logic [FILE_W-1:0] RST_FILE = 4'h1;
  localparam logic [STEP_W-1:0] RST_STEP = 5'h01;
  localparam logic [BANK_W-1:0] RST_BANK = 8'h01;
  localparam logic [TIME_W-1:0] RST_TIME = 14'h0064;
  localparam logic [TIME_W-1:0] RST_REP  = 14'h0000;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : asq_pkg

// ### hw/asq_ms_timer.sv
// Millisecond step timer: one expiry pulse after ms_count milliseconds
`timescale 1ns/1ns
module asq_ms_timer
  import asq_pkg::*;
#(
  parameter int CYC_PER_MS = CYCLES_PER_MS
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              start,
  input  wire logic [TIME_W-1:0] ms_count,
  output logic                   expired
);
  logic              active;
  logic [TIME_W-1:0] ms_left;
  logic [31:0]       cyc;

  // Cycle prescaler and millisecond down counter; a new start restarts
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      active  <= 1'b0;
      ms_left <= '0;
      cyc     <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        active  <= 1'b1;
        ms_left <= ms_count;
        cyc     <= '0;
      end else if (active) begin
        if (cyc == 32'(CYC_PER_MS - 1)) begin
          cyc <= '0;
          if (ms_left <= 14'h0001) begin
            active  <= 1'b0;
            expired <= 1'b1;
          end else begin
            ms_left <= ms_left - 14'h0001;
          end
        end else begin
          cyc <= cyc + 32'h0000_0001;
        end
      end
    end
  end
endmodule : asq_ms_timer

// ### tb/asq_host_model.sv
// Host model: APB master that issues command register transfers
`timescale 1ns/1ns
module asq_host_model (
  input  wire logic        core_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'hFF;
    pwdata  = 32'h0;
  end

  // Setup, then access held until pready is sampled high at an edge
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse, so a stale value never looks valid
    paddr   <= ~addr;
    pwdata  <= ~wdata;
  endtask : xfer
endmodule : asq_host_model

// ### tb/asq_cmd_unit_tb.sv
// Self-checking testbench for the auto sequence command unit
`timescale 1ns/1ns
module asq_cmd_unit_tb;
  import asq_pkg::*;
  // Short millisecond so a whole run stays near a thousand cycles
  localparam int CPM = 2;
  logic              core_clk = 1'b0;
  logic              reset    = 1'b1;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              recall_valid;
  logic [BANK_W-1:0] recall_slot;
  logic              done_reply;
  logic              testing;
  int                num_errors = 0;
  int                num_checks = 0;
  int                cyc = 0;
  int                done_cnt = 0;
  logic [7:0]        slot_q[$];
  int                stamp_q[$];

  always #50 core_clk = ~core_clk;

  asq_host_model i_host (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  asq_cmd_unit #(.CYC_PER_MS(CPM)) i_dut (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .recall_valid(recall_valid),
    .recall_slot(recall_slot), .done_reply(done_reply), .testing(testing));

  // Log every recall pulse with its cycle and count completion replies
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (recall_valid === 1'b1) begin
      slot_q.push_back(recall_slot);
      stamp_q.push_back(cyc);
    end
    if (done_reply === 1'b1) begin
      done_cnt <= done_cnt + 1;
    end
  end

  // ---------------------------------------------------------------
  // Bus helpers and comparison
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    i_host.xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    i_host.xfer(1'b0, a, 32'h0, d, e);
    chk_word(what, exp, d);
  endtask : chk_reg

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk_reg("file", OFS_FILE, 32'h1);
    chk_reg("step", OFS_STEP, 32'h1);
    chk_reg("total", OFS_TOTAL, 32'h1);
    chk_reg("bank", OFS_BANK, 32'h1);
    chk_reg("time", OFS_TIME, 32'h64);
    chk_reg("repeat", OFS_REPEAT, 32'h0);
    chk_reg("status", OFS_STATUS, 32'h0);
    $display("test reset values done");
  endtask : t_reset

  // Both bounds taken, one past each bound dropped with the flag raised
  task automatic t_range(input string name, input logic [7:0] a,
                         input logic [31:0] lo, input logic [31:0] hi);
    wr(a, lo);
    chk_reg(name, a, lo);
    wr(a, hi);
    chk_reg(name, a, hi);
    wr(a, hi + 32'h1);
    chk_reg(name, a, hi);
    chk_reg("reject flag", OFS_STATUS, 32'h4);
    wr(OFS_STATUS, 32'h4);
    chk_reg("reject clear", OFS_STATUS, 32'h0);
    wr(a, lo - 32'h1);
    chk_reg(name, a, hi);
    chk_reg("reject flag", OFS_STATUS, 32'h4);
    wr(OFS_STATUS, 32'h4);
    $display("test range %s done", name);
  endtask : t_range

  // Settings stay with their file and step
  task automatic t_per_file();
    wr(OFS_FILE, 32'h2);
    wr(OFS_TOTAL, 32'h5);
    wr(OFS_REPEAT, 32'h7);
    wr(OFS_STEP, 32'h3);
    wr(OFS_BANK, 32'h7);
    wr(OFS_TIME, 32'hC8);
    wr(OFS_STEP, 32'h4);
    wr(OFS_BANK, 32'h9);
    wr(OFS_FILE, 32'h3);
    chk_reg("total f3", OFS_TOTAL, 32'h1);
    chk_reg("repeat f3", OFS_REPEAT, 32'h0);
    chk_reg("bank f3", OFS_BANK, 32'h1);
    wr(OFS_FILE, 32'h2);
    chk_reg("file", OFS_FILE, 32'h2);
    chk_reg("total f2", OFS_TOTAL, 32'h5);
    chk_reg("repeat f2", OFS_REPEAT, 32'h7);
    chk_reg("bank s4", OFS_BANK, 32'h9);
    wr(OFS_STEP, 32'h3);
    chk_reg("bank s3", OFS_BANK, 32'h7);
    chk_reg("time s3", OFS_TIME, 32'hC8);
    $display("test per file done");
  endtask : t_per_file

  task automatic t_unmapped();
    logic [31:0] d;
    logic        e;
    i_host.xfer(1'b0, 8'h24, 32'h0, d, e);
    chk_word("pslverr 24", 32'h1, {31'h0, e});
    i_host.xfer(1'b0, 8'h02, 32'h0, d, e);
    chk_word("pslverr 02", 32'h1, {31'h0, e});
    chk_reg("save read", OFS_SAVE, 32'h0);
    chk_reg("run read", OFS_RUN, 32'h0);
    $display("test unmapped done");
  endtask : t_unmapped

  // Two steps, two passes; unsaved edit must not reach the run
  task automatic t_run();
    int n;
    int d0;
    int dt;
    wr(OFS_FILE, 32'h4);
    wr(OFS_TOTAL, 32'h2);
    wr(OFS_STEP, 32'h1);
    wr(OFS_BANK, 32'h5);
    wr(OFS_TIME, 32'h64);
    wr(OFS_STEP, 32'h2);
    wr(OFS_BANK, 32'h6);
    wr(OFS_TIME, 32'h96);
    wr(OFS_REPEAT, 32'h1);
    wr(OFS_SAVE, 32'h0);
    wr(OFS_STEP, 32'h1);
    wr(OFS_BANK, 32'h8);
    wr(OFS_RUN, 32'h0);
    chk_reg("run 0 rejected", OFS_STATUS, 32'h4);
    wr(OFS_STATUS, 32'h4);
    slot_q.delete();
    stamp_q.delete();
    d0 = done_cnt;
    wr(OFS_RUN, 32'h4);
    chk_reg("testing status", OFS_STATUS, 32'h1);
    chk_word("testing", 32'h1, {31'h0, testing});
    wr(OFS_RUN, 32'h4);
    chk_reg("run while busy", OFS_STATUS, 32'h5);
    wr(OFS_STATUS, 32'h4);
    n = 0;
    while (done_cnt == d0 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    chk_word("done pulses", 32'h1, done_cnt - d0);
    chk_word("testing end", 32'h0, {31'h0, testing});
    chk_word("recalls", 32'h4, slot_q.size());
    for (int i = 0; i < 4 && i < slot_q.size(); i++) begin
      chk_word("slot", (i % 2 == 0) ? 32'h5 : 32'h6, {24'h0, slot_q[i]});
    end
    for (int i = 1; i < 4 && i < stamp_q.size(); i++) begin
      dt = stamp_q[i] - stamp_q[i-1];
      n = (i % 2 == 1) ? 100 * CPM : 150 * CPM;
      chk_word("step time", 32'h1, {31'h0, (dt >= n && dt <= n + 4)});
    end
    chk_reg("done flag", OFS_STATUS, 32'h2);
    wr(OFS_STATUS, 32'h2);
    chk_reg("done clear", OFS_STATUS, 32'h0);
    $display("test run done");
  endtask : t_run

  // ---------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_range("file", OFS_FILE, 32'h1, 32'h9);
    t_range("step", OFS_STEP, 32'h1, 32'h10);
    t_range("total", OFS_TOTAL, 32'h1, 32'h10);
    t_range("bank", OFS_BANK, 32'h1, 32'h96);
    t_range("time", OFS_TIME, 32'h64, 32'h270F);
    t_range("repeat", OFS_REPEAT, 32'h0, 32'h270F);
    t_per_file();
    t_unmapped();
    t_run();
    close_out();
  end

  // Watchdog well beyond the roughly one and a half thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
endmodule : asq_cmd_unit_tb
